// ===== pes_pkg.sv
// constants and carrier types for the pin-electronics serial port
// assumes a serial master in mode with host sampling on falling sclk
`default_nettype none

package pes_pkg;

    // frame layout: channel, address, read flag, data, msb first
    localparam int FRAME_BITS  = 26;
    localparam int HDR_BITS    = 10;
    localparam int DATA_BITS   = 16;
    localparam int CH_BITS     = 2;
    localparam int ADDR_BITS   = 7;
    localparam int CNT_BITS    = 5;

    // level converters
    localparam int DAC_COUNT   = 24;
    localparam int DAC_PER_CH  = 12;

    // address map; upper three address bits pick the block
    localparam logic [6:0] ADDR_NOP    = 7'h00;
    localparam logic [6:0] ADDR_CTRL   = 7'h12;
    localparam logic [2:0] BLK_LEVEL   = 3'h2;
    localparam logic [2:0] BLK_GAIN    = 3'h4;
    localparam logic [2:0] BLK_OFFSET  = 3'h6;

    // control register fields and resets
    localparam int          CTRL_FLOAT_BIT = 1;
    localparam logic [15:0] CTRL_RST       = 16'h0000;
    localparam logic [15:0] GAIN_RST       = 16'h8000;
    localparam logic [15:0] OFFSET_RST     = 16'h0000;
    localparam logic [15:0] LEVEL_RST      = 16'h0000;
    localparam int          GAIN_SHIFT     = 15;

    typedef struct packed {
        logic [CH_BITS-1:0]   channel_select_field;
        logic [ADDR_BITS-1:0] addr;
        logic                 rd;
        logic [DATA_BITS-1:0] data;
    } pes_frame_t;

    typedef struct packed {
        logic [CH_BITS-1:0]   channel_select_field;
        logic [ADDR_BITS-1:0] addr;
        logic [DATA_BITS-1:0] data;
    } pes_readback_t;

    typedef logic [DAC_COUNT-1:0][DATA_BITS-1:0] pes_level_t;

endpackage : pes_pkg

`default_nettype wire

// ===== pes_serial_port.sv
// serial programming port with level converters and gain/offset correction
// assumes i_sclk idles low, host shifts sdi and samples sdo on falling edge, port takes sdi on rising
`default_nettype none

// Summary of operation
// - float set: drive sdo only while selected
// - float set: sdo released until next select
// - float clear: sdo always driven
// - readout echoes request channel and address
// - read flag position outputs zero
// - then sixteen data bits of the addressed register
// - level writes corrected by gain, offset
// - twenty-four addressable sixteen-bit level converters
module pes_serial_port (
    input  wire logic               i_clk,
    input  wire logic               i_rst_n,
    input  wire logic               i_sclk,
    input  wire logic               i_cs_n,
    input  wire logic               i_sdi,
    output logic                    o_sdo,
    output logic                    o_sdo_oe,
    output pes_pkg::pes_level_t     o_dac_level
);
    import pes_pkg::*;

    // ---------------- link domain (i_sclk) ----------------
    logic [CNT_BITS-1:0]   cnt_reg;
    logic [FRAME_BITS-2:0] shift_reg;
    pes_frame_t            frame_reg;
    logic                  frame_tgl_reg;
    logic                  sdo_reg;
    pes_readback_t         rb_reg;

    // counter cleared while deselected so each frame starts at bit zero
    wire link_rst_n = i_rst_n & ~i_cs_n;
    wire last_bit   = (cnt_reg == CNT_BITS'(FRAME_BITS - 1));
    wire in_frame   = (cnt_reg < CNT_BITS'(FRAME_BITS));

    // readback word rests while a frame runs; written in i_clk domain long before
    wire [FRAME_BITS-1:0] tx_word = {rb_reg.channel_select_field, rb_reg.addr, 1'b0,
                                     rb_reg.data};
    wire [CNT_BITS-1:0]   tx_idx  = CNT_BITS'(FRAME_BITS - 1) - cnt_reg;
    wire                  tx_bit  = in_frame ? tx_word[tx_idx] : 1'b0;

    always_ff @(posedge i_sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            cnt_reg <= '0;
        end else if (in_frame) begin
            cnt_reg <= cnt_reg + CNT_BITS'(1);
        end
    end

    always_ff @(posedge i_sclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_reg     <= '0;
            frame_reg     <= '0;
            frame_tgl_reg <= 1'b0;
            sdo_reg       <= 1'b0;
        end else if (!i_cs_n) begin
            shift_reg <= {shift_reg[FRAME_BITS-3:0], i_sdi};
            sdo_reg   <= tx_bit;
            if (last_bit) begin
                frame_reg     <= {shift_reg, i_sdi};
                frame_tgl_reg <= ~frame_tgl_reg;
            end
        end
    end

    assign o_sdo = sdo_reg;

    // ---------------- system domain (i_clk) ----------------
    logic [1:0]     cs_sync_reg;
    logic [2:0]     tgl_sync_reg;
    logic [15:0]    ctrl_reg;
    logic           oe_reg;
    pes_level_t     level_reg;
    pes_level_t     gain_reg;
    pes_level_t     offset_reg;

    wire        cs_act    = cs_sync_reg[1];
    wire        frame_evt = tgl_sync_reg[2] ^ tgl_sync_reg[1];
    wire        float_q   = ctrl_reg[CTRL_FLOAT_BIT];
    pes_frame_t fr;
    assign fr = frame_reg;

    // decode of the captured frame
    wire [2:0]  blk      = fr.addr[6:4];
    wire [3:0]  local_a  = fr.addr[3:0];
    wire        idx_ok   = ~fr.channel_select_field[1] && (local_a < 4'(DAC_PER_CH));
    wire [4:0]  idx      = {1'b0, local_a}
                           + (fr.channel_select_field[0] ? 5'(DAC_PER_CH) : 5'd0);
    wire        is_level = idx_ok && (blk == BLK_LEVEL);
    wire        is_gain  = idx_ok && (blk == BLK_GAIN);
    wire        is_off   = idx_ok && (blk == BLK_OFFSET);
    wire        is_ctrl  = (fr.addr == ADDR_CTRL);

    // correction: level = data * gain / 2^15 + offset, clamped to range
    wire [31:0] prod     = 32'(fr.data) * 32'(gain_reg[idx]);
    wire [16:0] scaled   = prod[31:GAIN_SHIFT];
    wire [17:0] sum      = {1'b0, scaled} + {{2{offset_reg[idx][15]}}, offset_reg[idx]};
    wire [15:0] corr     = sum[17] ? 16'h0000 : (sum[16] ? 16'hFFFF : sum[15:0]);

    wire [15:0] rd_val   = is_level ? level_reg[idx]  :
                           is_gain  ? gain_reg[idx]   :
                           is_off   ? offset_reg[idx] :
                           is_ctrl  ? ctrl_reg        : 16'h0000;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cs_sync_reg  <= '0;
            tgl_sync_reg <= '0;
            oe_reg       <= 1'b0;
        end else begin
            cs_sync_reg  <= {cs_sync_reg[0], ~i_cs_n};
            tgl_sync_reg <= {tgl_sync_reg[1:0], frame_tgl_reg};
            oe_reg       <= ~float_q | cs_act;
        end
    end

    assign o_sdo_oe = oe_reg;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_reg <= CTRL_RST;
            rb_reg   <= '0;
            for (int i = 0; i < DAC_COUNT; i++) begin
                level_reg[i]  <= LEVEL_RST;
                gain_reg[i]   <= GAIN_RST;
                offset_reg[i] <= OFFSET_RST;
            end
        end else if (frame_evt) begin
            if (fr.rd) begin
                // shown in the next frame the host sends
                rb_reg <= '{fr.channel_select_field, fr.addr, rd_val};
            end else if (is_level) begin
                level_reg[idx] <= corr;
            end else if (is_gain) begin
                gain_reg[idx] <= fr.data;
            end else if (is_off) begin
                offset_reg[idx] <= fr.data;
            end else if (is_ctrl) begin
                ctrl_reg <= fr.data;
            end
        end
    end

    assign o_dac_level = level_reg;

    // ---------------- checks ----------------
    sequence s_float_sel;
        float_q && cs_act;
    endsequence

    sequence s_float_desel;
        float_q && !cs_act;
    endsequence

    a_float_drive_sel: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_float_sel |=> o_sdo_oe)
        else $error("sdo not driven while selected");

    a_float_release: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_float_desel ##1 s_float_desel |-> !o_sdo_oe)
        else $error("sdo driven while deselected");

    a_nofloat_drive: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !float_q ##1 !float_q |-> o_sdo_oe)
        else $error("sdo floated with float control clear");

    a_echo_header: assert property (@(posedge i_sclk) disable iff (!link_rst_n)
        cnt_reg == 5'd0 |=> o_sdo == rb_reg.channel_select_field[1] ##8 1'b1
            ##0 o_sdo == rb_reg.addr[0])
        else $error("header echo wrong");

    a_rw_zero: assert property (@(posedge i_sclk) disable iff (!link_rst_n)
        cnt_reg == 5'd9 |=> !o_sdo)
        else $error("read flag position not zero");

    // falling edge: no rising sclk follows the last data bit before select rises
    a_data_bits: assert property (@(negedge i_sclk) disable iff (!link_rst_n)
        cnt_reg == 5'd11 |-> o_sdo == rb_reg.data[15] ##15 o_sdo == rb_reg.data[0])
        else $error("readout data bits wrong");

    a_level_unity: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        frame_evt && !fr.rd && is_level && gain_reg[idx] == GAIN_RST
            && offset_reg[idx] == 16'h0000 |=> level_reg[$past(idx)] == $past(fr.data))
        else $error("unity correction altered level");

    a_level_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !frame_evt |=> $stable(level_reg))
        else $error("level changed without a frame");

    a_frame_done: assert property (@(negedge i_sclk) disable iff (!link_rst_n)
        $past(cnt_reg) == 5'd25
            |-> cnt_reg == 5'd26 && frame_tgl_reg != $past(frame_tgl_reg))
        else $error("frame not closed at bit 26");

    a_count_stop: assert property (@(negedge i_sclk) disable iff (!link_rst_n)
        cnt_reg <= 5'd26)
        else $error("bit counter ran past the frame");

    a_rb_header: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        frame_evt && fr.rd |=> rb_reg.addr == $past(fr.addr)
            && rb_reg.channel_select_field == $past(fr.channel_select_field))
        else $error("readback header not taken from request");

    a_rb_level: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        frame_evt && fr.rd && is_level |=> rb_reg.data == level_reg[$past(idx)])
        else $error("readback data not the stored level");

    a_gain_store: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        frame_evt && !fr.rd && is_gain |=> gain_reg[$past(idx)] == $past(fr.data))
        else $error("gain coefficient not stored");

    a_ctrl_store: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        frame_evt && !fr.rd && is_ctrl |=> float_q == $past(fr.data[CTRL_FLOAT_BIT]))
        else $error("float control not stored");

    a_bad_channel: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        frame_evt && fr.channel_select_field[1] |=> $stable(level_reg))
        else $error("level written on an unused channel");

endmodule // pes_serial_port

`default_nettype wire

// ===== pes_host_model.sv
// serial master standing in for the test-system host controller
// assumes the port shifts sdo on rising sclk; sampled here on falling sclk
`default_nettype none
module pes_host_model
    import pes_pkg::*;
(
    output var logic o_sclk,
    output var logic o_cs_n,
    output var logic o_sdi,
    input  wire logic i_sdo
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi  = 1'b0;
    end
    // one whole frame; sclk stands still outside it
    task automatic xfer(input pes_frame_t f, output logic [FRAME_BITS-1:0] rx);
        logic [FRAME_BITS-1:0] bits;
        bits = f;
        o_cs_n = 1'b0;
        // select lead covers the enable's three system-clock latency
        #200;
        for (int k = FRAME_BITS - 1; k >= 0; k--) begin
            o_sdi = bits[k];
            #15 o_sclk = 1'b1;
            #15 o_sclk = 1'b0;
            rx[k] = i_sdo;
        end
        #15 o_cs_n = 1'b1;
        o_sdi = ~bits[0];
        // gap before next frame, covers the apply latency
        #500;
    endtask
endmodule // pes_host_model
`default_nettype wire

// ===== pes_serial_port_test.sv
// self-checking bench for the serial port and level converters
// assumes the host model drives the link and a 50 ns system clock
`default_nettype none
module pes_serial_port_test
    import pes_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk = 1'b0;
    logic                  rst_n = 1'b0;
    wire                   sclk;
    wire                   cs_n;
    wire                   sdi;
    logic                  sdo;
    logic                  sdo_oe;
    pes_level_t            lvl;
    wire                   sdo_wire = sdo_oe ? sdo : 1'bz;
    logic [FRAME_BITS-1:0] rx;
    int                    num_errors = 0;
    int                    checks_done = 0;
    always #25 clk = ~clk;
    pes_serial_port u_pes_serial_port (.i_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_dac_level(lvl));
    pes_host_model u_pes_host_model (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi),
        .i_sdo(sdo_wire));
    task automatic chk(input string what, input logic [25:0] seen, input logic [25:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic go(input logic [1:0] ch, input logic [6:0] a, input logic r,
                      input logic [15:0] d);
        u_pes_host_model.xfer(pes_frame_t'{ch, a, r, d}, rx);
    endtask
    task automatic test_done();
        if (num_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic t_correct();
        go(2'd0, 7'h40, 1'b0, 16'h4000);
        go(2'd0, 7'h60, 1'b0, 16'h0010);
        go(2'd0, 7'h20, 1'b0, 16'h1000);
        go(2'd1, 7'h2B, 1'b0, 16'hABCD);
        go(2'd2, 7'h20, 1'b0, 16'hFFFF);
        chk("level0", {10'h0, lvl[0]}, 26'h000_0810);
        chk("level23", {10'h0, lvl[23]}, 26'h000_ABCD);
    endtask
    task automatic t_readback();
        go(2'd0, 7'h40, 1'b1, 16'hFFFF);
        go(2'd1, 7'h2B, 1'b1, 16'h0000);
        chk("gain echo", rx, {2'd0, 7'h40, 1'b0, 16'h4000});
        go(2'd0, ADDR_NOP, 1'b0, 16'h5A5A);
        chk("level echo", rx, {2'd1, 7'h2B, 1'b0, 16'hABCD});
    endtask
    task automatic t_float();
        go(2'd0, ADDR_CTRL, 1'b0, 16'h0002);
        chk("oe idle", {25'h0, sdo_oe}, 26'h0);
        chk("wire idle", {25'h0, sdo_wire}, {25'h0, 1'bz});
        go(2'd0, ADDR_CTRL, 1'b1, 16'h0000);
        go(2'd0, ADDR_NOP, 1'b0, 16'h0000);
        chk("ctrl echo", rx, {2'd0, ADDR_CTRL, 1'b0, 16'h0002});
        chk("wire after", {25'h0, sdo_wire}, {25'h0, 1'bz});
        go(2'd0, ADDR_CTRL, 1'b0, 16'h0000);
        chk("oe driven", {25'h0, sdo_oe}, 26'h1);
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk("oe reset", {25'h0, sdo_oe}, 26'h1);
        t_correct();
        t_readback();
        t_float();
        test_done();
    end
endmodule // pes_serial_port_test
`default_nettype wire
